// File: include/clock_sysref_params.svh
// Purpose: Offsets, field positions, reset values for the clock and sync-ref registers
// Assumes: Byte addresses on the plain register port
// Notes:   Definitions only
`ifndef CLOCK_SYSREF_PARAMS_SVH
`define CLOCK_SYSREF_PARAMS_SVH

`define ADDR_W                 8
`define OFS_CLOCK_INPUT_CTRL   8'h2A
`define OFS_SAMPLE_CLK_TUNING  8'h2B
`define OFS_SYNC_EDGE_POS      8'h2C
`define OFS_CHAN_A_FULL_SCALE  8'h30
`define RST_CLOCK_INPUT_CTRL   8'h00
`define RST_SAMPLE_CLK_TUNING  8'h11
`define RST_SYNC_EDGE_POS      24'h000000
`define RST_CHAN_A_FULL_SCALE  16'hA000
`define MASK_CLOCK_INPUT_CTRL  8'h0F
`define MASK_SAMPLE_CLK_TUNING 8'h17
`define BIT_POLARITY_INVERT    0
`define BIT_SYNC_DC_MODE       1
`define BIT_DEVCLK_DC_MODE     2
`define BIT_MARKER_ENABLE      3
`define BIT_DELAY_SEL_LO       0
`define BIT_DELAY_SEL_HI       1
`define BIT_NOISE_SUPPRESS     2
`define BIT_FEEDBACK_GAIN      4
`define DECIM_BYPASS           8'h01

`endif

// File: include/clock_sysref_pkg.sv
// Purpose: Types shared by the clock and sync-ref register block
// Assumes: Constants live in the params header
// Notes:   Types only
package clock_sysref_pkg;
    typedef logic [7:0]  reg8_t;
    typedef logic [23:0] reg24_t;
    typedef logic [15:0] reg16_t;
endpackage

// File: rtl/clock_sysref_control_regs.sv
// What this block does
// - Both enables put sync-ref on sample LSB
// - Marker only when decimation equals one
// - Marker enable picks sync-ref over timestamp pin
// - Bit 2 sets device clock DC mode
// - Bit 1 sets sync-ref DC mode
// - Bit 0 inverts sync-ref polarity
// - Clock input register resets to zero
// - Tuning register resets 0x11, reserved read zero
// - Bit 4 feedback gain, high is one
// - Bits 1:0 one-hot delay, reset lowest
// - Position register returns 24-bit edge status
// - Position read-only, writes ignored
// - Full-scale register at 0x30 resets 0xA000
//
// Purpose: Clock and sync-ref configuration and status registers
// Assumes: Plain register port, read data one cycle after the strobe
// Notes:   Unmapped reads return zero, unmapped writes are dropped
`timescale 1ns/100ps
`include "clock_sysref_params.svh"
`default_nettype none
module clock_sysref_control_regs #(
    parameter int SAMPLE_W = 12
) (
    input  wire logic                clock_in,
    input  wire logic                reset_n_in,
    input  wire logic [7:0]          addr_in,
    input  wire logic [31:0]         wdata_in,
    input  wire logic                write_in,
    input  wire logic                read_in,
    output logic      [31:0]         rdata_out,
    input  wire logic                sync_ref_pin_in,
    input  wire logic                timestamp_pin_in,
    input  wire logic                timestamp_out_enable_in,
    input  wire logic [7:0]          decimation_in,
    input  wire logic                edge_capture_in,
    input  wire logic [23:0]         edge_position_in,
    input  wire logic [SAMPLE_W-1:0] sample_in,
    output logic      [SAMPLE_W-1:0] sample_out,
    output logic                     device_clock_dc_input_mode_out,
    output logic                     sync_ref_dc_input_mode_out,
    output logic                     sync_ref_polarity_invert_out,
    output logic                     feedback_gain_high_out,
    output logic                     supply_noise_suppress_out,
    output logic      [1:0]          sample_clock_delay_select_out,
    output logic      [15:0]         channel_a_full_scale_out,
    output logic                     aligned_sync_ref_out,
    output logic                     marker_source_out
);
    clock_sysref_pkg::reg8_t  clock_input_control_r;
    clock_sysref_pkg::reg8_t  clock_input_control_nxt;
    clock_sysref_pkg::reg8_t  sample_clock_tuning_r;
    clock_sysref_pkg::reg8_t  sample_clock_tuning_nxt;
    clock_sysref_pkg::reg24_t sync_edge_position_r;
    clock_sysref_pkg::reg24_t sync_edge_position_nxt;
    clock_sysref_pkg::reg16_t channel_a_full_scale_r;
    clock_sysref_pkg::reg16_t channel_a_full_scale_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [1:0]  sync_meta_r;
    logic [1:0]  stamp_meta_r;
    logic        aligned_r;
    logic        aligned_nxt;
    logic        source_r;
    logic        source_nxt;
    logic        marker_on;
    logic        marker_enable;

    // Register read mux, used by the read path only
    function automatic logic [31:0] read_value(input logic [7:0] a,
                                               input clock_sysref_pkg::reg8_t c1,
                                               input clock_sysref_pkg::reg8_t c2,
                                               input clock_sysref_pkg::reg24_t pos,
                                               input clock_sysref_pkg::reg16_t fs);
        logic [31:0] v;
        v = 32'h00000000;
        unique case (a)
            `OFS_CLOCK_INPUT_CTRL:  v = {24'h000000, c1};
            `OFS_SAMPLE_CLK_TUNING: v = {24'h000000, c2};
            `OFS_SYNC_EDGE_POS:     v = {8'h00, pos};
            `OFS_CHAN_A_FULL_SCALE: v = {16'h0000, fs};
            default:                v = 32'h00000000;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: pins are outside the clock domain
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sync_meta_r  <= 2'h0;
            stamp_meta_r <= 2'h0;
        end else begin
            sync_meta_r  <= {sync_meta_r[0], sync_ref_pin_in};
            stamp_meta_r <= {stamp_meta_r[0], timestamp_pin_in};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes and status capture
    always_comb begin
        clock_input_control_nxt  = clock_input_control_r;
        sample_clock_tuning_nxt  = sample_clock_tuning_r;
        channel_a_full_scale_nxt = channel_a_full_scale_r;
        sync_edge_position_nxt   = sync_edge_position_r;
        if (write_in) begin
            unique case (addr_in)
                `OFS_CLOCK_INPUT_CTRL:
                    clock_input_control_nxt = wdata_in[7:0] & `MASK_CLOCK_INPUT_CTRL;
                `OFS_SAMPLE_CLK_TUNING:
                    sample_clock_tuning_nxt = wdata_in[7:0] & `MASK_SAMPLE_CLK_TUNING;
                `OFS_CHAN_A_FULL_SCALE:
                    channel_a_full_scale_nxt = wdata_in[15:0];
                default: ; // Position is read-only; unmapped dropped
            endcase
        end
        // Only a captured edge changes the position word
        if (edge_capture_in) begin
            sync_edge_position_nxt = edge_position_in;
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            clock_input_control_r  <= `RST_CLOCK_INPUT_CTRL;
            sample_clock_tuning_r  <= `RST_SAMPLE_CLK_TUNING;
            sync_edge_position_r   <= `RST_SYNC_EDGE_POS;
            channel_a_full_scale_r <= `RST_CHAN_A_FULL_SCALE;
        end else begin
            clock_input_control_r  <= clock_input_control_nxt;
            sample_clock_tuning_r  <= sample_clock_tuning_nxt;
            sync_edge_position_r   <= sync_edge_position_nxt;
            channel_a_full_scale_r <= channel_a_full_scale_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data, valid the cycle after the strobe only
    always_comb begin
        rdata_nxt = 32'h00000000;
        if (read_in) begin
            rdata_nxt = read_value(addr_in, clock_input_control_r, sample_clock_tuning_r,
                                   sync_edge_position_r, channel_a_full_scale_r);
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_r <= 32'h00000000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sync-ref alignment level and marker source
    assign marker_enable = clock_input_control_r[`BIT_MARKER_ENABLE];
    // Marking needs both enables and a bypassed decimator
    assign marker_on = marker_enable && timestamp_out_enable_in
                       && (decimation_in == `DECIM_BYPASS);

    always_comb begin
        // Invert before alignment sees it
        aligned_nxt = sync_meta_r[1] ^ clock_input_control_r[`BIT_POLARITY_INVERT];
        // Enable swaps the marker source to sync-ref
        source_nxt  = marker_enable ? aligned_nxt : stamp_meta_r[1];
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            aligned_r <= 1'b0;
            source_r  <= 1'b0;
        end else begin
            aligned_r <= aligned_nxt;
            source_r  <= source_nxt;
        end
    end

    // Sample path with LSB marker
    sample_marker #(
        .SAMPLE_W (SAMPLE_W)
    ) u_marker (
        .clock_in        (clock_in),
        .reset_n_in      (reset_n_in),
        .sample_in       (sample_in),
        .marker_on_in    (marker_on),
        .marker_level_in (aligned_nxt),
        .sample_out      (sample_out)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from registers
    assign rdata_out                      = rdata_r;
    assign device_clock_dc_input_mode_out = clock_input_control_r[`BIT_DEVCLK_DC_MODE];
    assign sync_ref_dc_input_mode_out     = clock_input_control_r[`BIT_SYNC_DC_MODE];
    assign sync_ref_polarity_invert_out   = clock_input_control_r[`BIT_POLARITY_INVERT];
    assign feedback_gain_high_out         = sample_clock_tuning_r[`BIT_FEEDBACK_GAIN];
    assign supply_noise_suppress_out      = sample_clock_tuning_r[`BIT_NOISE_SUPPRESS];
    assign sample_clock_delay_select_out  =
        sample_clock_tuning_r[`BIT_DELAY_SEL_HI:`BIT_DELAY_SEL_LO];
    assign channel_a_full_scale_out       = channel_a_full_scale_r;
    assign aligned_sync_ref_out           = aligned_r;
    assign marker_source_out              = source_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_reset_values: assert property (@(posedge clock_in)
        $rose(reset_n_in) |-> (clock_input_control_r == 8'h00) && (sample_clock_tuning_r == 8'h11)
                              && (channel_a_full_scale_r == 16'hA000))
        else $error("Reset values wrong");
    a_reserved_zero: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (clock_input_control_r[7:4] == 4'h0) && (sample_clock_tuning_r[7:5] == 3'h0)
        && !sample_clock_tuning_r[3])
        else $error("Reserved bits not zero");
    a_pos_readonly: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        !edge_capture_in |=> $stable(sync_edge_position_r))
        else $error("Position changed without capture");
    a_pos_readback: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (read_in && addr_in == 8'h2C) |=> rdata_out == {8'h00, $past(sync_edge_position_r)})
        else $error("Position readback wrong");
    a_fs_write: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (write_in && addr_in == 8'h30) |=> channel_a_full_scale_out == $past(wdata_in[15:0]))
        else $error("Full-scale write lost");
    a_gain_write: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (write_in && addr_in == 8'h2B) |=> feedback_gain_high_out == $past(wdata_in[4])
                                          && sample_clock_delay_select_out == $past(wdata_in[1:0]))
        else $error("Tuning write lost");
    a_dc_modes: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (write_in && addr_in == 8'h2A) |=> device_clock_dc_input_mode_out == $past(wdata_in[2])
                                          && sync_ref_dc_input_mode_out == $past(wdata_in[1]))
        else $error("DC mode write lost");
    // Aligned level follows the previous cycle's synced pin and invert bit
    a_invert_path: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        $stable(clock_input_control_r) |=>
            aligned_sync_ref_out == ($past(sync_meta_r[1]) ^ $past(clock_input_control_r[0])))
        else $error("Polarity path wrong");
    a_marker_lsb: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        marker_on |=> sample_out[0] == $past(aligned_nxt))
        else $error("Marker not on LSB");
    a_no_marker: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (decimation_in != 8'h01) |=> sample_out == $past(sample_in))
        else $error("Marker with decimation");
    a_source_sel: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (!clock_input_control_r[3] && $stable(clock_input_control_r)) |=>
            marker_source_out == $past(stamp_meta_r[1]))
        else $error("Marker source wrong");

    // Write masks, status load and idle read data
    a_ctrl_mask: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (write_in && addr_in == 8'h2A) |=>
            clock_input_control_r == ($past(wdata_in[7:0]) & 8'h0F))
        else $error("Clock input mask wrong");
    a_tuning_mask: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (write_in && addr_in == 8'h2B) |=>
            sample_clock_tuning_r == ($past(wdata_in[7:0]) & 8'h17))
        else $error("Tuning mask wrong");
    a_invert_write: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (write_in && addr_in == 8'h2A) |=> sync_ref_polarity_invert_out == $past(wdata_in[0]))
        else $error("Invert write lost");
    a_pos_capture: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        edge_capture_in |=> sync_edge_position_r == $past(edge_position_in))
        else $error("Position capture lost");
    a_rdata_idle: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        !read_in |=> rdata_out == 32'h00000000)
        else $error("Read data outside read cycle");

    // Marker needs both enables; either one low passes the sample
    a_marker_gate: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (!marker_enable || !timestamp_out_enable_in) |=> sample_out == $past(sample_in))
        else $error("Marker without both enables");
    a_source_sync: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (clock_input_control_r[3] && $stable(clock_input_control_r)) |=>
            marker_source_out == $past(aligned_nxt))
        else $error("Marker source not sync-ref");
endmodule
`default_nettype wire

// File: rtl/sample_marker.sv
// Purpose: Puts the sync-ref level on the sample LSB when the marker path is on
// Assumes: Sync-ref level already synchronised and polarity corrected
// Notes:   Registered output, one cycle of latency
`timescale 1ns/100ps
`include "clock_sysref_params.svh"
`default_nettype none
module sample_marker #(
    parameter int SAMPLE_W = 12
) (
    input  wire logic                clock_in,
    input  wire logic                reset_n_in,
    input  wire logic [SAMPLE_W-1:0] sample_in,
    input  wire logic                marker_on_in,
    input  wire logic                marker_level_in,
    output logic      [SAMPLE_W-1:0] sample_out
);
    logic [SAMPLE_W-1:0] sample_r;
    logic [SAMPLE_W-1:0] sample_nxt;

    // Replace LSB only while marking
    always_comb begin
        sample_nxt = sample_in;
        if (marker_on_in) begin
            sample_nxt[0] = marker_level_in;
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sample_r <= '0;
        end else begin
            sample_r <= sample_nxt;
        end
    end

    assign sample_out = sample_r;
endmodule
`default_nettype wire

// File: verif/tb.sv
// Purpose: Self-checking bench for the clock and sync-ref register block
// Assumes: Plain register port, read data one cycle after the read strobe
// Notes:   Each scenario is its own task; only mismatches and the verdict print
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        clock_in;
    logic        reset_n_in;
    logic [7:0]  addr_in;
    logic [31:0] wdata_in;
    logic        write_in;
    logic        read_in;
    logic [31:0] rdata_out;
    logic        sync_pin;
    logic        ts_pin;
    logic        ts_en;
    logic [7:0]  decim;
    logic        cap;
    logic [23:0] cap_pos;
    logic [11:0] smp_in;
    logic [11:0] smp_out;
    logic        dev_dc;
    logic        sync_dc;
    logic        inv;
    logic        gain;
    logic        noise;
    logic [1:0]  dly;
    logic [15:0] fs;
    logic        aligned;
    logic        source;
    int          fails;
    int          checked;
    logic [31:0] d;

    clock_sysref_control_regs #(.SAMPLE_W(12)) dut (
        .clock_in(clock_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in),
        .rdata_out(rdata_out), .sync_ref_pin_in(sync_pin), .timestamp_pin_in(ts_pin),
        .timestamp_out_enable_in(ts_en), .decimation_in(decim),
        .edge_capture_in(cap), .edge_position_in(cap_pos), .sample_in(smp_in),
        .sample_out(smp_out), .device_clock_dc_input_mode_out(dev_dc),
        .sync_ref_dc_input_mode_out(sync_dc), .sync_ref_polarity_invert_out(inv),
        .feedback_gain_high_out(gain), .supply_noise_suppress_out(noise),
        .sample_clock_delay_select_out(dly), .channel_a_full_scale_out(fs),
        .aligned_sync_ref_out(aligned), .marker_source_out(source));

    ////////////////////////////////////////////////////////////////////////////
    // Clock at 50 ns, watchdog at 3000 cycles, well past the roughly 80 cycles needed
    initial begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end

    initial begin
        #(50 * 3000);
        fails = fails + 1;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Strobe one cycle, outputs settled just after the following edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock_in);
        addr_in  <= a;
        wdata_in <= v;
        write_in <= 1'b1;
        @(posedge clock_in);
        write_in <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock_in);
        addr_in <= a;
        read_in <= 1'b1;
        @(posedge clock_in);
        read_in <= 1'b0;
        #1 v = rdata_out;
    endtask

    task automatic print_verdict();
        if (fails == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset_values();
        rd(8'h2A, d); chk("ctrl1 reset", d, 32'h00);
        rd(8'h2B, d); chk("tuning reset", d, 32'h11);
        chk("gain reset", {31'h0, gain}, 32'h1);
        chk("delay reset", {30'h0, dly}, 32'h1);
        rd(8'h30, d); chk("full scale reset", d, 32'hA000);
        chk("full scale port", {16'h0, fs}, 32'hA000);
        rd(8'h55, d); chk("unmapped read", d, 32'h0);
    endtask

    // All ones written to 0x2A, 0xEE to 0x2B; reserved bits must come back zero
    task automatic t_field_bits();
        wr(8'h2A, 32'hFF);
        chk("dc clock mode", {31'h0, dev_dc}, 32'h1);
        chk("dc sync mode", {31'h0, sync_dc}, 32'h1);
        chk("invert", {31'h0, inv}, 32'h1);
        rd(8'h2A, d); chk("ctrl1 masked", d, 32'h0F);
        wr(8'h2A, 32'h04);
        chk("dc sync off", {30'h0, sync_dc, inv}, 32'h0);
        chk("dc clock alone", {31'h0, dev_dc}, 32'h1);
        wr(8'h2B, 32'hEE);
        chk("gain low", {31'h0, gain}, 32'h0);
        chk("noise on", {31'h0, noise}, 32'h1);
        chk("delay two", {30'h0, dly}, 32'h2);
        rd(8'h2B, d); chk("tuning masked", d, 32'h06);
        wr(8'h30, 32'h1234_5678);
        rd(8'h30, d); chk("full scale rw", d, 32'h5678);
    endtask

    // Capture loads status, software writes leave it alone
    task automatic t_position();
        @(posedge clock_in);
        cap_pos <= 24'hC3A5F0;
        cap     <= 1'b1;
        @(posedge clock_in);
        // Delay select comes from tuning bits 1:0 and still holds two here
        cap     <= 1'b0;
        // Software picks its delay from this status word
        rd(8'h2C, d); chk("position capture", d, 32'hC3A5F0);
        wr(8'h2C, 32'h00FFFFFF);
        rd(8'h2C, d); chk("position read only", d, 32'hC3A5F0);
    endtask

    // Marker on LSB needs both enables and bypass decimation
    task automatic t_marker(input logic [7:0] c1, input logic en, input logic [7:0] dm,
                            input logic pin, input logic tsp, input logic exp_lsb);
        wr(8'h2A, {24'h0, c1});
        @(posedge clock_in);
        ts_en    <= en;
        decim    <= dm;
        sync_pin <= pin;
        ts_pin   <= tsp;
        repeat (5) @(posedge clock_in);
        #1;
        chk("sample lsb", {20'h0, smp_out}, {20'h0, smp_in[11:1], exp_lsb});
        chk("aligned", {31'h0, aligned}, {31'h0, pin ^ c1[0]});
        chk("source", {31'h0, source}, {31'h0, c1[3] ? (pin ^ c1[0]) : tsp});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        fails      = 0;
        checked    = 0;
        reset_n_in = 1'b0;
        addr_in    = 8'h00;
        wdata_in   = 32'h0;
        write_in   = 1'b0;
        read_in    = 1'b0;
        sync_pin   = 1'b0;
        ts_pin     = 1'b0;
        ts_en      = 1'b0;
        decim      = 8'h01;
        cap        = 1'b0;
        cap_pos    = 24'h0;
        smp_in     = 12'hAB0;
        repeat (2) @(posedge clock_in);
        reset_n_in <= 1'b1;
        t_reset_values();
        t_field_bits();
        t_position();
        t_marker(8'h08, 1'b1, 8'h01, 1'b1, 1'b0, 1'b1);
        t_marker(8'h09, 1'b1, 8'h01, 1'b1, 1'b1, 1'b0);
        t_marker(8'h08, 1'b0, 8'h01, 1'b1, 1'b0, 1'b0);
        t_marker(8'h08, 1'b1, 8'h02, 1'b1, 1'b0, 1'b0);
        t_marker(8'h00, 1'b1, 8'h01, 1'b1, 1'b1, 1'b0);
        t_marker(8'h01, 1'b0, 8'h04, 1'b0, 1'b0, 1'b0);
        print_verdict();
    end
endmodule
`default_nettype wire
